/* File: hdl/arsc_edge.sv */
// module: rising edge pulse generator for synchronised request levels
`timescale 1ns/1ps
`default_nettype none
module arsc_edge #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // level in, pulse out
  input  wire logic [WIDTH-1:0] i_level,
  output logic      [WIDTH-1:0] o_rise
);
  logic [WIDTH-1:0] last_r;

  // ==========================================================================
  // remember last level; pulse is combinational on a registered level
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      last_r <= '0;
    end else begin
      last_r <= i_level;
    end
  end

  assign o_rise = i_level & ~last_r;
endmodule : arsc_edge
`default_nettype wire

/* File: hdl/arsc_pkg.sv */
// package: constants, register offsets and types of the restart sequence control block
package arsc_pkg;
  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;
  localparam logic [7:0] ADDR_CFG    = 8'h10;
  localparam logic [7:0] ADDR_LIST   = 8'h14;
  // ==========================================================================
  // control register bit positions
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_LIST_SWAP_REQUEST_SIGNAL  = 1;
  localparam int CTRL_ABORT   = 2;
  localparam int CTRL_TRIGGER = 3;
  // config register bit positions
  localparam int CFG_TRIGGER_BIT_MODE = 0;
  localparam int CFG_DBL_BUF   = 1;
  // interrupt status bit positions
  localparam int IRQ_RESTART  = 0;
  localparam int IRQ_ABORT    = 1;
  localparam int IRQ_TRIGGER_BIT_ERR = 2;
  localparam int IRQ_WIDTH    = 3;
  // status register bit positions
  localparam int ST_RESTART   = 0;
  localparam int ST_LIST_SWAP_REQUEST_SIGNAL    = 1;
  localparam int ST_ABORT     = 2;
  localparam int ST_TRIGGER   = 3;
  localparam int ST_TRIGGER_BIT_ERR  = 4;
  localparam int ST_RVL_DONE  = 5;
  localparam int ST_BUF_SEL   = 6;
  localparam int ST_HALTED    = 7;
  localparam int ST_STATE_LSB = 8;
  // list index / unmapped read value
  localparam int          LIST_IDX_W = 8;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
  // ==========================================================================
  // sequencer flow states
  typedef enum logic [2:0] {
    ARSC_IDLE    = 3'b000,
    ARSC_ABORT   = 3'b001,
    ARSC_RESTART = 3'b010,
    ARSC_TRIGGER = 3'b011,
    ARSC_LOAD    = 3'b100,
    ARSC_HALT    = 3'b101
  } arsc_state_t;
endpackage : arsc_pkg

/* File: hdl/arsc_sync.sv */
// module: two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module arsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : arsc_sync
`default_nettype wire

/* File: hdl/arsc_top.sv */
// module: restart, abort, trigger and list swap flow control of a converter sequencer
//
// Summary of operation
// [RQ1] every restart event sets restart request bit
// [RQ2] running unfinished list without abort: also abort
// [RQ3] idle and results not done: also abort
// [RQ4] results done after end-of-list or abort
// [RQ5] abort first then restart, else restart only
// [RQ6] trigger mode idle done: set trigger, restart
// [RQ7] restart with trigger together: error, stop
// [RQ8] swap: index to top, toggle buffer
// [RQ9] interface restart samples swap signal into load-ok
// [RQ10] bus write restart plus load-ok swaps
// [RQ11] first top command load clears both bits
// [RQ12] requester swaps only when converter idle
// [RQ13] interface and bus requests merged identically
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module arsc_top (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // internal request interface (asynchronous levels)
  input  wire logic        i_restart,
  input  wire logic        i_list_swap_request_signal,
  input  wire logic        i_abort,
  input  wire logic        i_trigger,
  // converter progress (same clock)
  input  wire logic        i_conv_busy,
  input  wire logic        i_end_of_list,
  input  wire logic        i_first_cmd_load,
  // sequencer view
  output logic      [7:0]  o_list_index,
  output logic             o_buffer_select,
  output logic             o_seq_abort,
  output logic             o_seq_restart,
  output logic             o_seq_trigger,
  output logic             o_halted,
  output logic             o_irq
);
  // ==========================================================================
  // signals
  localparam int IRQW = arsc_pkg::IRQ_WIDTH;
  logic [3:0]               sync_lv;
  logic [2:0]               if_rise;
  logic                     ack_r;
  logic                     acc;
  logic                     wr_acc;
  logic                     rd_acc;
  logic                     restart_request_bit_r;
  logic                     load_ok_bit_r;
  logic                     load_ok_by_restart_r;
  logic                     sequence_abort_bit_r;
  logic                     trigger_bit_r;
  logic                     trigger_error_flag_r;
  logic                     eol_seen_r;
  logic                     abort_done_r;
  logic                     trigger_bit_mode_r;
  logic                     dbl_buf_r;
  logic [IRQW-1:0]          irq_st_r;
  logic [IRQW-1:0]          irq_mk_r;
  arsc_pkg::arsc_state_t    state_r;
  arsc_pkg::arsc_state_t    state_nxt;
  logic                     bus_restart;
  logic                     bus_list_swap_request_signal;
  logic                     bus_abort;
  logic                     bus_trigger;
  logic                     restart_ev;
  logic                     abort_set;
  logic                     trigger_ev;
  logic                     rvl_done;
  logic                     need_abort;
  logic                     auto_trigger_bit;
  logic                     trigger_bit_clash;
  logic                     swap_ev;
  logic                     top_loaded;
  logic [IRQW-1:0]          irq_ev;
  logic [31:0]              status_word;

  // ==========================================================================
  // internal interface: two flops, then edge detect on restart, abort and trigger only
  arsc_sync #(.WIDTH(4)) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_trigger, i_abort, i_list_swap_request_signal, i_restart}),
    .o_sync  (sync_lv)
  );

  arsc_edge #(.WIDTH(3)) u_edge (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_level ({sync_lv[3], sync_lv[2], sync_lv[0]}),
    .o_rise  (if_rise)
  );

  // ==========================================================================
  // bus decode: one wait cycle, then ack
  assign acc    = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_acc = i_avs_write & ack_r;
  assign rd_acc = i_avs_read & ~ack_r;

  // waitrequest low only in the ack cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_r             <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ack_r             <= acc;
      o_avs_waitrequest <= ~acc;
    end
  end

  // control strobes from a bus write of ones (byte lane 0)
  always_comb begin
    bus_restart = 1'b0;
    bus_list_swap_request_signal  = 1'b0;
    bus_abort   = 1'b0;
    bus_trigger = 1'b0;
    if (wr_acc && i_avs_byteenable[0] && i_avs_address == arsc_pkg::ADDR_CTRL) begin
      bus_restart = i_avs_writedata[arsc_pkg::CTRL_RESTART];
      bus_list_swap_request_signal  = i_avs_writedata[arsc_pkg::CTRL_LIST_SWAP_REQUEST_SIGNAL];
      bus_abort   = i_avs_writedata[arsc_pkg::CTRL_ABORT];
      bus_trigger = i_avs_writedata[arsc_pkg::CTRL_TRIGGER];
    end
  end

  // ==========================================================================
  // event merging and abort decision
  // [RQ13] both sources merged
  assign restart_ev = if_rise[0] | bus_restart;
  assign trigger_ev = if_rise[2] | bus_trigger;
  // [RQ4] done after end-of-list or abort
  assign rvl_done   = eol_seen_r | sequence_abort_bit_r | abort_done_r | if_rise[1] | bus_abort;
  // [RQ2] running, list unfinished, no abort pending
  // [RQ3] idle with results not done
  assign need_abort = restart_ev & ~rvl_done;
  assign abort_set  = need_abort | if_rise[1] | bus_abort;
  // [RQ7] simultaneous restart and trigger in trigger mode
  assign trigger_bit_clash = trigger_bit_mode_r & restart_ev & trigger_ev;
  // [RQ6] idle and done in trigger mode
  assign auto_trigger_bit  = trigger_bit_mode_r & restart_ev & ~i_conv_busy & rvl_done & ~trigger_bit_clash;
  // [RQ10] bus swap needs restart and load-ok in one write
  // [RQ9] interface restart samples swap level
  assign swap_ev    = (if_rise[0] & sync_lv[1]) | (bus_restart & bus_list_swap_request_signal);
  // [RQ11] top command load ends the restart
  assign top_loaded = i_first_cmd_load & (o_list_index == '0);

  // ==========================================================================
  // control bits: set wins over clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      restart_request_bit_r <= 1'b0;
      load_ok_bit_r         <= 1'b0;
      load_ok_by_restart_r  <= 1'b0;
    end else begin
      // [RQ1] restart sets request bit
      if (restart_ev) begin
        restart_request_bit_r <= 1'b1;
      end else if (top_loaded) begin
        restart_request_bit_r <= 1'b0;
      end
      // [RQ11] load-ok cleared only if set by restart
      if (swap_ev) begin
        load_ok_bit_r        <= 1'b1;
        load_ok_by_restart_r <= 1'b1;
      end else if (top_loaded && load_ok_by_restart_r) begin
        load_ok_bit_r        <= 1'b0;
        load_ok_by_restart_r <= 1'b0;
      end
    end
  end

  // abort bit, trigger bit and error flag
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sequence_abort_bit_r <= 1'b0;
      trigger_bit_r        <= 1'b0;
      trigger_error_flag_r <= 1'b0;
    end else begin
      if (abort_set) begin
        sequence_abort_bit_r <= 1'b1;
      end else if (state_r == arsc_pkg::ARSC_ABORT) begin
        sequence_abort_bit_r <= 1'b0;
      end
      if (auto_trigger_bit || (trigger_ev && !trigger_bit_clash)) begin
        trigger_bit_r <= 1'b1;
      end else if (state_r == arsc_pkg::ARSC_TRIGGER) begin
        trigger_bit_r <= 1'b0;
      end
      // [RQ7] error flag is sticky until reset
      if (trigger_bit_clash) begin
        trigger_error_flag_r <= 1'b1;
      end
    end
  end

  // result-list done tracking
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      eol_seen_r   <= 1'b0;
      abort_done_r <= 1'b0;
    end else begin
      if (i_end_of_list) begin
        eol_seen_r <= 1'b1;
      end else if (top_loaded) begin
        eol_seen_r <= 1'b0;
      end
      if (state_r == arsc_pkg::ARSC_ABORT) begin
        abort_done_r <= 1'b1;
      end else if (top_loaded) begin
        abort_done_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // flow sequencer
  // [RQ5] abort before restart, then trigger if requested
  // a trigger clash is taken by the state register itself, from any state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      arsc_pkg::ARSC_IDLE: begin
        if (sequence_abort_bit_r) begin
          state_nxt = arsc_pkg::ARSC_ABORT;
        end else if (restart_request_bit_r) begin
          state_nxt = arsc_pkg::ARSC_RESTART;
        end else if (trigger_bit_r) begin
          state_nxt = arsc_pkg::ARSC_TRIGGER;
        end
      end
      arsc_pkg::ARSC_ABORT:   state_nxt = restart_request_bit_r ? arsc_pkg::ARSC_RESTART : arsc_pkg::ARSC_IDLE;
      arsc_pkg::ARSC_RESTART: state_nxt = trigger_bit_r ? arsc_pkg::ARSC_TRIGGER : arsc_pkg::ARSC_LOAD;
      arsc_pkg::ARSC_TRIGGER: state_nxt = arsc_pkg::ARSC_LOAD;
      arsc_pkg::ARSC_LOAD: begin
        if (top_loaded || !restart_request_bit_r) begin
          state_nxt = arsc_pkg::ARSC_IDLE;
        end
      end
      arsc_pkg::ARSC_HALT:    state_nxt = arsc_pkg::ARSC_HALT;
      default:                state_nxt = arsc_pkg::ARSC_IDLE;
    endcase
  end

  // halt is left only by reset: the converter has ceased operation
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= arsc_pkg::ARSC_IDLE;
    end else if (trigger_bit_clash) begin
      state_r <= arsc_pkg::ARSC_HALT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sequencer strobes, one cycle per step; halted is held until reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_seq_abort   <= 1'b0;
      o_seq_restart <= 1'b0;
      o_seq_trigger <= 1'b0;
      o_halted      <= 1'b0;
    end else begin
      o_seq_abort   <= (state_nxt == arsc_pkg::ARSC_ABORT) && !trigger_bit_clash;
      o_seq_restart <= (state_nxt == arsc_pkg::ARSC_RESTART) && !trigger_bit_clash;
      o_seq_trigger <= (state_nxt == arsc_pkg::ARSC_TRIGGER) && !trigger_bit_clash;
      o_halted      <= (state_nxt == arsc_pkg::ARSC_HALT) || trigger_bit_clash;
    end
  end

  // ==========================================================================
  // list index and buffer select
  // [RQ8] restart goes to top, swap toggles buffer
  // [RQ12] swap assumed only while idle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_list_index    <= '0;
      o_buffer_select <= 1'b0;
    end else begin
      if (state_r == arsc_pkg::ARSC_RESTART) begin
        o_list_index <= '0;
        if (load_ok_bit_r && dbl_buf_r) begin
          o_buffer_select <= ~o_buffer_select;
        end
      end else if (i_first_cmd_load && !i_end_of_list) begin
        o_list_index <= o_list_index + 8'h01;
      end
    end
  end

  // ==========================================================================
  // configuration and interrupts
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      trigger_bit_mode_r <= 1'b0;
      dbl_buf_r   <= 1'b0;
      irq_mk_r    <= '0;
    end else if (wr_acc && i_avs_byteenable[0]) begin
      if (i_avs_address == arsc_pkg::ADDR_CFG) begin
        trigger_bit_mode_r <= i_avs_writedata[arsc_pkg::CFG_TRIGGER_BIT_MODE];
        dbl_buf_r   <= i_avs_writedata[arsc_pkg::CFG_DBL_BUF];
      end
      if (i_avs_address == arsc_pkg::ADDR_IRQ_MK) begin
        irq_mk_r <= i_avs_writedata[IRQW-1:0];
      end
    end
  end

  assign irq_ev = {trigger_bit_clash, abort_set, restart_ev};

  // sticky status; a new event wins over a write-one clear; irq lags one cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_st_r <= '0;
      o_irq    <= 1'b0;
    end else begin
      o_irq <= |(irq_st_r & irq_mk_r);
      if (wr_acc && i_avs_byteenable[0] && i_avs_address == arsc_pkg::ADDR_IRQ_ST) begin
        irq_st_r <= (irq_st_r & ~i_avs_writedata[IRQW-1:0]) | irq_ev;
      end else begin
        irq_st_r <= irq_st_r | irq_ev;
      end
    end
  end

  // ==========================================================================
  // read data, registered in the wait cycle
  always_comb begin
    status_word = arsc_pkg::READ_ZERO;
    status_word[arsc_pkg::ST_RESTART]  = restart_request_bit_r;
    status_word[arsc_pkg::ST_LIST_SWAP_REQUEST_SIGNAL]   = load_ok_bit_r;
    status_word[arsc_pkg::ST_ABORT]    = sequence_abort_bit_r;
    status_word[arsc_pkg::ST_TRIGGER]  = trigger_bit_r;
    status_word[arsc_pkg::ST_TRIGGER_BIT_ERR] = trigger_error_flag_r;
    status_word[arsc_pkg::ST_RVL_DONE] = rvl_done;
    status_word[arsc_pkg::ST_BUF_SEL]  = o_buffer_select;
    status_word[arsc_pkg::ST_HALTED]   = o_halted;
    status_word[arsc_pkg::ST_STATE_LSB +: 3] = state_r;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= arsc_pkg::READ_ZERO;
    end else if (rd_acc) begin
      case (i_avs_address)
        arsc_pkg::ADDR_CTRL:   o_avs_readdata <= {28'h0000000, trigger_bit_r, sequence_abort_bit_r, load_ok_bit_r,
                                                  restart_request_bit_r};
        arsc_pkg::ADDR_STATUS: o_avs_readdata <= status_word;
        arsc_pkg::ADDR_IRQ_ST: o_avs_readdata <= {29'h0000000, irq_st_r};
        arsc_pkg::ADDR_IRQ_MK: o_avs_readdata <= {29'h0000000, irq_mk_r};
        arsc_pkg::ADDR_CFG:    o_avs_readdata <= {30'h0000000, dbl_buf_r, trigger_bit_mode_r};
        arsc_pkg::ADDR_LIST:   o_avs_readdata <= {24'h000000, o_list_index};
        default:               o_avs_readdata <= arsc_pkg::READ_ZERO;
      endcase
    end
  end
endmodule : arsc_top
`default_nettype wire

/* File: test/arsc_req_model.sv */
// partner model: internal restart, swap and trigger request levels
`timescale 1ns/1ps
`default_nettype none
module arsc_req_model (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // bench commands and converter state
  input  wire logic i_go,
  input  wire logic i_want_swap,
  input  wire logic i_with_trigger_bit,
  input  wire logic i_conv_busy,
  // request levels
  output logic      o_restart,
  output logic      o_swap,
  output logic      o_trigger
);
  // ====
  // swap level first, restart held 4 cycles, then low long enough for the sync
  logic [3:0] cnt_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_r     <= 4'h0;
      o_restart <= 1'b0;
      o_swap    <= 1'b0;
      o_trigger <= 1'b0;
    end else begin
      if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      else if (i_go) cnt_r <= 4'hC;
      // swap offered only with converter idle
      if (cnt_r == 4'hC) o_swap <= i_want_swap & ~i_conv_busy;
      if (cnt_r == 4'hB) o_restart <= 1'b1;
      if (cnt_r == 4'hB) o_trigger <= i_with_trigger_bit;
      if (cnt_r == 4'h7) o_restart <= 1'b0;
      if (cnt_r == 4'h7) o_trigger <= 1'b0;
      if (cnt_r == 4'h5) o_swap <= 1'b0;
    end
  end
endmodule : arsc_req_model
`default_nettype wire

/* File: test/arsc_top_sva.sv */
// checker: bus timing and sequencer step order of the restart control block
`timescale 1ns/1ps
`default_nettype none
module arsc_top_sva (
  // clock, reset and bus
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // requests and sequencer view
  input wire logic        i_restart,
  input wire logic [7:0]  o_list_index,
  input wire logic        o_buffer_select,
  input wire logic        o_seq_abort,
  input wire logic        o_seq_restart,
  input wire logic        o_seq_trigger,
  input wire logic        o_halted
);
  // ====
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // abort step ends while the block is not halted
  sequence s_abort_ends;
    $fell(o_seq_abort) && !o_halted;
  endsequence
  sequence s_restart_follows;
    ##[0:4] o_seq_restart;
  endsequence
  // quiet sequencer seeing a fresh interface restart
  sequence s_quiet_restart;
    $rose(i_restart) && !o_halted && !o_seq_abort && !o_seq_restart && !o_seq_trigger;
  endsequence
  a_req_gets_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered after one cycle");
  a_ack_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_reads_zero: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address > arsc_pkg::ADDR_LIST
    |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
  a_readdata_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
    else $error("read data changed without a read");
  a_steps_exclusive: assert property ($onehot0({o_seq_abort, o_seq_restart, o_seq_trigger}))
    else $error("two sequencer steps at once");
  a_abort_then_restart: assert property (s_abort_ends |-> s_restart_follows)
    else $error("restart step missing after abort step");
  a_halt_stops_steps: assert property (o_halted |=> o_halted && !o_seq_restart && !o_seq_trigger)
    else $error("converter not stopped after trigger error");
  a_swap_at_top: assert property ($changed(o_buffer_select)
    |-> o_list_index == 8'h00 || $past(o_list_index) == 8'h00)
    else $error("buffer swapped away from list top");
  a_restart_answered: assert property (s_quiet_restart
    |-> ##[3:12] (o_seq_abort || o_seq_restart || o_halted))
    else $error("interface restart produced no step");
endmodule : arsc_top_sva
bind arsc_top arsc_top_sva u_arsc_top_sva (.i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .i_restart, .o_list_index, .o_buffer_select, .o_seq_abort,
  .o_seq_restart, .o_seq_trigger, .o_halted);
`default_nettype wire

/* File: test/tb_adc_restart_sequence_control.sv */
// testbench: restart, abort, swap and trigger flow of the restart control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_restart_sequence_control;
  // ====
  // stimulus and observed signals
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        wreq;
  logic        busy = 1'b0;
  logic [1:0]  pls = 2'b00;
  logic        go = 1'b0;
  logic        want_swap = 1'b0;
  logic        with_trigger_bit = 1'b0;
  logic        rq_restart;
  logic        rq_swap;
  logic        rq_trigger_bit;
  logic [7:0]  idx;
  logic        bsel;
  logic        irq;
  logic [3:0]  seqv;
  logic        saw_ab = 1'b0;
  logic [31:0] d;
  logic        b0;
  int          n_mismatch = 0;
  int          check_count = 0;
  always #5 i_clock = ~i_clock;
  // byteenable tied full and abort pin idle: abort is reached through restarts
  arsc_top u_arsc_top (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_restart(rq_restart), .i_list_swap_request_signal(rq_swap),
    .i_abort(1'b0), .i_trigger(rq_trigger_bit), .i_conv_busy(busy), .i_end_of_list(pls[0]),
    .i_first_cmd_load(pls[1]), .o_list_index(idx), .o_buffer_select(bsel), .o_seq_abort(seqv[0]),
    .o_seq_restart(seqv[1]), .o_seq_trigger(seqv[2]), .o_halted(seqv[3]), .o_irq(irq));
  arsc_req_model u_arsc_req_model (.i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_want_swap(want_swap),
    .i_with_trigger_bit(with_trigger_bit), .i_conv_busy(busy), .o_restart(rq_restart), .o_swap(rq_swap), .o_trigger(rq_trigger_bit));
  // remember any abort step since the last clear
  always @(posedge i_clock) begin
    if (seqv[0] === 1'b1) saw_ab <= 1'b1;
  end
  // ====
  // helpers
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic chk1(input string nm, input logic exp, input logic got);
    check(nm, {31'h0, exp}, {31'h0, got});
  endtask : chk1
  // one avalon cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_clock);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= dat;
    do begin
      @(posedge i_clock);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    chk1("bus answer", 1'b0, wreq);
  endtask : bus
  task automatic wait_step(input int k, input string nm);
    int n;
    n = 0;
    while (seqv[k] !== 1'b1 && n < 40) begin
      @(posedge i_clock);
      n++;
    end
    chk1(nm, 1'b1, seqv[k]);
  endtask : wait_step
  // pulse 0 is end of list, pulse 1 is first command load
  task automatic pulse(input int k);
    @(posedge i_clock);
    pls[k] <= 1'b1;
    @(posedge i_clock);
    pls[k] <= 1'b0;
  endtask : pulse
  task automatic ifc(input logic s, input logic t);
    @(posedge i_clock);
    want_swap <= s;
    with_trigger_bit <= t;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
  endtask : ifc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ====
  // scenarios
  task automatic t_bus_restart();
    bus(1'b1, arsc_pkg::ADDR_IRQ_MK, 32'h0000_0001);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, d);
    bus(1'b1, arsc_pkg::ADDR_CTRL, 32'h0000_0001);
    wait_step(0, "abort step idle");
    wait_step(1, "restart step");
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("restart bit", 1'b1, d[arsc_pkg::ST_RESTART]);
    chk1("irq raised", 1'b1, irq);
    pulse(1);
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("restart cleared", 1'b0, d[arsc_pkg::ST_RESTART]);
    bus(1'b1, arsc_pkg::ADDR_IRQ_ST, 32'h0000_0001);
    bus(1'b1, arsc_pkg::ADDR_IRQ_MK, 32'h0000_0000);
    chk1("irq cleared", 1'b0, irq);
  endtask : t_bus_restart
  task automatic t_ifc_plain();
    saw_ab <= 1'b0;
    pulse(0);
    ifc(1'b0, 1'b0);
    wait_step(1, "restart step");
    chk1("no abort when done", 1'b0, saw_ab);
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("load-ok stays clear", 1'b0, d[arsc_pkg::ST_LIST_SWAP_REQUEST_SIGNAL]);
    chk1("irq masked", 1'b0, irq);
    bus(1'b0, arsc_pkg::ADDR_IRQ_ST, 32'h0000_0000);
    chk1("restart event", 1'b1, d[arsc_pkg::IRQ_RESTART]);
    bus(1'b1, arsc_pkg::ADDR_IRQ_ST, 32'h0000_0007);
    pulse(1);
  endtask : t_ifc_plain
  task automatic t_ifc_swap();
    bus(1'b1, arsc_pkg::ADDR_CFG, 32'h0000_0002);
    b0 = bsel;
    pulse(0);
    ifc(1'b1, 1'b0);
    wait_step(1, "swap restart step");
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    check("index at top", 32'h0000_0000, {24'h0, idx});
    chk1("load-ok set", 1'b1, d[arsc_pkg::ST_LIST_SWAP_REQUEST_SIGNAL]);
    pulse(1);
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("buffer swapped", ~b0, bsel);
    chk1("load-ok cleared", 1'b0, d[arsc_pkg::ST_LIST_SWAP_REQUEST_SIGNAL]);
  endtask : t_ifc_swap
  task automatic t_bus_swap();
    b0 = bsel;
    pulse(0);
    bus(1'b1, arsc_pkg::ADDR_CTRL, 32'h0000_0003);
    wait_step(1, "bus swap restart");
    pulse(1);
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("bus swap", ~b0, bsel);
  endtask : t_bus_swap
  task automatic t_busy_abort();
    saw_ab <= 1'b0;
    busy <= 1'b1;
    bus(1'b1, arsc_pkg::ADDR_CTRL, 32'h0000_0001);
    wait_step(0, "abort while busy");
    wait_step(1, "restart after abort");
    busy <= 1'b0;
    pulse(1);
  endtask : t_busy_abort
  task automatic t_trigger_bit();
    bus(1'b1, arsc_pkg::ADDR_CFG, 32'h0000_0001);
    pulse(0);
    ifc(1'b0, 1'b0);
    wait_step(1, "restart before trigger");
    wait_step(2, "auto trigger");
    pulse(1);
    pulse(0);
    ifc(1'b0, 1'b1);
    wait_step(3, "halted");
    bus(1'b0, arsc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk1("trigger error", 1'b1, d[arsc_pkg::ST_TRIGGER_BIT_ERR]);
  endtask : t_trigger_bit
  // ====
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    t_bus_restart();
    t_ifc_plain();
    t_ifc_swap();
    t_bus_swap();
    t_busy_abort();
    t_trigger_bit();
    report_and_stop();
  end
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_adc_restart_sequence_control
`default_nettype wire
